// file: src/fpm_buf.sv
// Small FIFO with valid/ready on both sides
`timescale 1ns/100ps
module fpm_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];   // Entry storage
    logic [IW-1:0]    wr_idx;        // Next slot to fill
    logic [IW-1:0]    rd_idx;        // Oldest slot
    logic [CW-1:0]    count;         // Entries held

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_idx];

    // Storage write; no reset needed, guarded by count
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == IW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == IW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule

// file: src/fpm_pkg.sv
// Types shared by the multiplier block files
`include "fpm_regs.svh"
package fpm_pkg;
    // Value word, zero-extended from the configured width
    typedef logic [`FPM_MAX_W-1:0] fpm_word_type;

    // One result beat through pipe and buffer
    typedef struct packed {
        logic         valid;
        logic         load;
        logic [1:0]   status;
        fpm_word_type value;
    } fpm_beat_type;
endpackage

// file: src/fpm_regs.svh
// Offsets, fields, reset values and status codes of the multiplier block
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH

// Widest supported floating-point word
`define FPM_MAX_W          24

// Byte offsets
`define FPM_OFF_CTRL       4'h0
`define FPM_OFF_STATUS     4'h4
`define FPM_OFF_RESULT     4'h8
`define FPM_OFF_CONFIG     4'hC

// Control fields and reset value
`define FPM_CTRL_CAPTURE   0
`define FPM_CTRL_RESET     1'h1

// Status register fields
`define FPM_STAT_ST_LSB    0
`define FPM_STAT_NONEMPTY  8
`define FPM_STAT_FULL      9

// Result register fields
`define FPM_RES_ST_LSB     24
`define FPM_RES_VALID      31

// Config register fields
`define FPM_CFG_WIDTH_LSB  0
`define FPM_CFG_EXP_LSB    8
`define FPM_CFG_ACC        16
`define FPM_CFG_INREG      17
`define FPM_CFG_PIPE_LSB   20

// Result status codes
`define FPM_ST_NORM        2'h0
`define FPM_ST_ZERO        2'h1
`define FPM_ST_INF         2'h2
`define FPM_ST_UNDER       2'h3

// Bus responses
`define FPM_RESP_OKAY      2'h0
`define FPM_RESP_DECERR    2'h3

`endif

// file: src/fpm_stage.sv
// One register stage with clock enable and synchronous active-low reset
`timescale 1ns/100ps
module fpm_stage #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // Reset wins over enable
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

// file: src/fpm_top.sv
// Floating-point multiplier with optional accumulation and AXI4-Lite result port
// Behaviour
// - width is 16 or 24, default 16
// - exponent 5 or 8; 24 forces 8
// - no accumulation: result is plain product
// - restart high: drop accumulator, keep product
// - restart low: add product to previous result
// - restart strobe delayed alongside its operands
// - without accumulation restart strobe is ignored
// - each operand has own enable, shared reset
// - input registers add exactly one cycle
// - hidden input controls tie high internally
// - pipeline stages 0 to 4, default 0
// - latency is stages plus input register
// - hidden pipeline controls tie high internally
// - input reset is synchronous, active low
// - pipeline enable/reset also cover accumulator
// - two-bit status: normal, zero, infinity, underflow
`timescale 1ns/100ps
`include "fpm_regs.svh"
module fpm_top #(
    parameter int FP_WIDTH       = 16,
    parameter int EXP_SIZE       = 5,
    parameter bit ACCUM_EN       = 1'b0,
    parameter bit IN_REG_EN      = 1'b0,
    parameter bit HIDE_IN_CTRL   = 1'b0,
    parameter int PIPE_REGS      = 0,
    parameter bit HIDE_PIPE_CTRL = 1'b0,
    parameter int BUF_DEPTH      = 2
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Fabric operand side
    input  wire logic [FP_WIDTH-1:0] din_a,
    input  wire logic [FP_WIDTH-1:0] din_b,
    input  wire logic                din_valid,
    input  wire logic                acc_restart,
    input  wire logic                in_reg_a_ce,
    input  wire logic                in_reg_b_ce,
    input  wire logic                in_reg_rst_n,
    input  wire logic                pipe_ce,
    input  wire logic                pipe_rst_n,
    // Fabric result side
    output logic [FP_WIDTH-1:0]      dout,
    output logic [1:0]               dout_status,
    output logic                     dout_valid,
    output logic                     res_ready
);
    // Anything but 24 is 16; 24 forces 8 exponent bits
    localparam int W    = (FP_WIDTH == 24) ? 24 : 16;
    localparam int E    = (W == 24) ? 8 : ((EXP_SIZE == 8) ? 8 : 5);
    localparam int M    = W - 1 - E;
    localparam int NP   = (PIPE_REGS < 0) ? 0 : ((PIPE_REGS > 4) ? 4 : PIPE_REGS);
    localparam int BW   = $bits(fpm_pkg::fpm_beat_type);
    localparam logic [E-1:0]          EMAX = '1;
    localparam logic signed [E+1:0]   BIAS = (E+2)'((1 << (E - 1)) - 1);

    // Effective controls; hidden ones are tied high
    wire ce_a   = HIDE_IN_CTRL ? 1'b1 : in_reg_a_ce;
    wire ce_b   = HIDE_IN_CTRL ? 1'b1 : in_reg_b_ce;
    wire in_rn  = HIDE_IN_CTRL ? 1'b1 : in_reg_rst_n;
    wire p_ce   = HIDE_PIPE_CTRL ? 1'b1 : pipe_ce;
    wire p_rn   = HIDE_PIPE_CTRL ? 1'b1 : pipe_rst_n;
    // Block reset also clears every local register
    wire in_rst_n   = aresetn && in_rn;
    wire pipe_rst_n_all = aresetn && p_rn;

    // Multiply with truncation; denormal inputs flush to zero
    function automatic logic [W+1:0] fp_mul(input logic [W-1:0] a, input logic [W-1:0] b);
        logic              s;
        logic [E-1:0]      ea;
        logic [E-1:0]      eb;
        logic [2*M+1:0]    p;
        logic signed [E+1:0] ex;
        logic [M-1:0]      mr;
        s  = a[W-1] ^ b[W-1];
        ea = a[W-2:M];
        eb = b[W-2:M];
        p  = {1'b1, a[M-1:0]} * {1'b1, b[M-1:0]};
        ex = $signed({2'b00, ea}) + $signed({2'b00, eb}) - BIAS;
        if (p[2*M+1]) begin
            mr = p[2*M:M+1];
            ex = ex + (E+2)'(1);
        end else begin
            mr = p[2*M-1:M];
        end
        if (ea == '0 || eb == '0) begin
            fp_mul = {`FPM_ST_ZERO, s, {(W-1){1'b0}}};
        end else if (ea == EMAX || eb == EMAX || ex >= $signed({2'b00, EMAX})) begin
            fp_mul = {`FPM_ST_INF, s, EMAX, {M{1'b0}}};
        end else if (ex <= 0) begin
            fp_mul = {`FPM_ST_UNDER, s, {(W-1){1'b0}}};
        end else begin
            fp_mul = {`FPM_ST_NORM, s, ex[E-1:0], mr};
        end
    endfunction

    // Add with truncation; an exact cancel gives +0
    function automatic logic [W+1:0] fp_add(input logic [W-1:0] a, input logic [W-1:0] b);
        logic [W-1:0]        big;
        logic [W-1:0]        sml;
        logic [E-1:0]        d;
        logic [M+1:0]        mb;
        logic [M+1:0]        ms;
        logic [M+1:0]        sum;
        logic signed [E+1:0] ex;
        big = (a[W-2:0] >= b[W-2:0]) ? a : b;
        sml = (a[W-2:0] >= b[W-2:0]) ? b : a;
        d   = big[W-2:M] - sml[W-2:M];
        mb  = {2'b01, big[M-1:0]};
        ms  = {2'b01, sml[M-1:0]} >> d;
        sum = (big[W-1] == sml[W-1]) ? mb + ms : mb - ms;
        ex  = $signed({2'b00, big[W-2:M]});
        if (sum[M+1]) begin
            sum = sum >> 1;
            ex  = ex + (E+2)'(1);
        end
        for (int i = 0; i < M + 1; i++) begin
            if (!sum[M] && sum != '0) begin
                sum = sum << 1;
                ex  = ex - (E+2)'(1);
            end
        end
        if (big[W-2:M] == EMAX) begin
            fp_add = {`FPM_ST_INF, big[W-1], EMAX, {M{1'b0}}};
        end else if (sml[W-2:M] == '0) begin
            // Other operand zero: result is the larger
            fp_add = {(big[W-2:M] == '0) ? `FPM_ST_ZERO : `FPM_ST_NORM, big};
        end else if (sum == '0) begin
            fp_add = {`FPM_ST_ZERO, {W{1'b0}}};
        end else if (ex >= $signed({2'b00, EMAX})) begin
            fp_add = {`FPM_ST_INF, big[W-1], EMAX, {M{1'b0}}};
        end else if (ex <= 0) begin
            fp_add = {`FPM_ST_UNDER, big[W-1], {(W-1){1'b0}}};
        end else begin
            fp_add = {`FPM_ST_NORM, big[W-1], ex[E-1:0], sum[M-1:0]};
        end
    endfunction

    // Operand stage outputs
    logic [W-1:0] op_a;         // Operand A after optional register
    logic [W-1:0] op_b;         // Operand B after optional register
    logic [1:0]   op_tag;       // {valid, restart} after optional register

    // Restart dropped when accumulation is off
    wire restart_in = ACCUM_EN ? acc_restart : 1'b0;

    // Optional input registers, one per operand
    generate
        if (IN_REG_EN) begin : g_inreg
            fpm_stage #(.WIDTH(W)) u_reg_a (
                .aclk  (aclk),
                .rst_n (in_rst_n),
                .ce    (ce_a),
                .d     (din_a),
                .q     (op_a)
            );
            fpm_stage #(.WIDTH(W)) u_reg_b (
                .aclk  (aclk),
                .rst_n (in_rst_n),
                .ce    (ce_b),
                .d     (din_b),
                .q     (op_b)
            );
            // Restart and valid ride with the pair, so they need both enables
            fpm_stage #(.WIDTH(2)) u_reg_tag (
                .aclk  (aclk),
                .rst_n (in_rst_n),
                .ce    (ce_a && ce_b),
                .d     ({din_valid, restart_in}),
                .q     (op_tag)
            );
        end else begin : g_noinreg
            // No state at all in this path
            assign op_a   = din_a;
            assign op_b   = din_b;
            assign op_tag = {din_valid, restart_in};
        end
    endgenerate

    // Product beat entering the pipe
    wire [W+1:0] prod = fp_mul(op_a, op_b);
    fpm_pkg::fpm_beat_type pipe_in;
    assign pipe_in.valid  = op_tag[1];
    assign pipe_in.load   = op_tag[0];
    assign pipe_in.status = prod[W+1:W];
    assign pipe_in.value  = fpm_pkg::fpm_word_type'(prod[W-1:0]);

    // Pipeline chain; restart travels inside the beat
    wire [BW-1:0] chain [NP+1];
    assign chain[0] = pipe_in;
    generate
        for (genvar i = 0; i < NP; i++) begin : g_pipe
            fpm_stage #(.WIDTH(BW)) u_pipe (
                .aclk  (aclk),
                .rst_n (pipe_rst_n_all),
                .ce    (p_ce),
                .d     (chain[i]),
                .q     (chain[i+1])
            );
        end
    endgenerate
    fpm_pkg::fpm_beat_type pipe_out;
    assign pipe_out = chain[NP];
    wire [W-1:0] p_val = pipe_out.value[W-1:0];

    // Accumulate onto the stored previous result
    logic [W-1:0] acc_q;                                   // Accumulator register
    wire  [W+1:0] acc_sum = fp_add(p_val, acc_q);
    wire          take_prod = !ACCUM_EN || pipe_out.load;
    wire  [W-1:0] res_val = take_prod ? p_val : acc_sum[W-1:0];
    wire  [1:0]   res_st  = take_prod ? pipe_out.status : acc_sum[W+1:W];

    // Accumulator shares pipeline enable and reset
    generate
        if (ACCUM_EN) begin : g_acc
            fpm_stage #(.WIDTH(W)) u_acc (
                .aclk  (aclk),
                .rst_n (pipe_rst_n_all),
                .ce    (p_ce),
                .d     (res_val),
                .q     (acc_q)
            );
        end else begin : g_noacc
            assign acc_q = '0;
        end
    endgenerate

    // Straight out, so latency stays stages plus input register
    assign dout        = res_val;
    assign dout_status = res_st;
    assign dout_valid  = pipe_out.valid;

    // Register file state
    logic        cap_en;       // Copy results into the read buffer
    logic [3:0]  aw_addr_q;    // Held write address
    logic [31:0] w_data_q;     // Held write data
    logic [3:0]  w_strb_q;     // Held write strobes
    logic        aw_got;       // Write address taken
    logic        w_got;        // Write data taken

    // Read buffer; ready exported so fabric stalls rather than lose words
    fpm_pkg::fpm_beat_type buf_in;
    fpm_pkg::fpm_beat_type buf_out;
    logic                  buf_in_ready;
    logic                  buf_out_valid;
    assign buf_in.valid  = 1'b1;
    assign buf_in.load   = pipe_out.load;
    assign buf_in.status = res_st;
    assign buf_in.value  = fpm_pkg::fpm_word_type'(res_val);
    wire buf_push = dout_valid && cap_en && p_ce;
    assign res_ready = buf_in_ready || !cap_en;

    // Read side decode
    wire ar_hs    = s_axi_arvalid && s_axi_arready;
    wire rd_ctrl  = (s_axi_araddr == `FPM_OFF_CTRL);
    wire rd_stat  = (s_axi_araddr == `FPM_OFF_STATUS);
    wire rd_res   = (s_axi_araddr == `FPM_OFF_RESULT);
    wire rd_cfg   = (s_axi_araddr == `FPM_OFF_CONFIG);
    wire rd_hit   = rd_ctrl || rd_stat || rd_res || rd_cfg;
    wire buf_pop  = ar_hs && rd_res && buf_out_valid;

    fpm_buf #(.WIDTH(BW), .DEPTH(BUF_DEPTH)) u_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (buf_push),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out)
    );

    // Read data words
    wire [31:0] ctrl_word = 32'(cap_en) << `FPM_CTRL_CAPTURE;
    wire [31:0] stat_word = (32'(res_st) << `FPM_STAT_ST_LSB)
                          | (32'(buf_out_valid) << `FPM_STAT_NONEMPTY)
                          | (32'(!buf_in_ready) << `FPM_STAT_FULL);
    wire [31:0] res_word  = buf_out_valid ? ((32'(buf_out.value))
                          | (32'(buf_out.status) << `FPM_RES_ST_LSB)
                          | (32'h1 << `FPM_RES_VALID)) : 32'h0;
    wire [31:0] cfg_word  = (32'(W) << `FPM_CFG_WIDTH_LSB)
                          | (32'(E) << `FPM_CFG_EXP_LSB)
                          | (32'(ACCUM_EN) << `FPM_CFG_ACC)
                          | (32'(IN_REG_EN) << `FPM_CFG_INREG)
                          | (32'(NP) << `FPM_CFG_PIPE_LSB);
    wire [31:0] rd_word   = rd_ctrl ? ctrl_word :
                            rd_stat ? stat_word :
                            rd_res  ? res_word  :
                            rd_cfg  ? cfg_word  : 32'h0;

    // Write side decode
    wire do_write = aw_got && w_got && !s_axi_bvalid;
    wire wr_ctrl  = (aw_addr_q == `FPM_OFF_CTRL);
    wire wr_hit   = wr_ctrl || (aw_addr_q == `FPM_OFF_STATUS)
                  || (aw_addr_q == `FPM_OFF_RESULT) || (aw_addr_q == `FPM_OFF_CONFIG);

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Capture address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
        end else if (do_write) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got    <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got    <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write effect and response; read-only registers answer OKAY
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_en       <= `FPM_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FPM_RESP_OKAY;
        end else if (do_write) begin
            if (wr_ctrl && w_strb_q[0]) begin
                cap_en <= w_data_q[`FPM_CTRL_CAPTURE];
            end
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `FPM_RESP_OKAY : `FPM_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `FPM_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `FPM_RESP_OKAY : `FPM_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// file: tb/fpm_checker_asserts.sv
// Port-level checks on the multiplier block
`timescale 1ns/100ps
module fpm_checker #(
    parameter int FP_WIDTH = 16
) (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                in_reg_rst_n,
    input wire logic                pipe_rst_n,
    input wire logic [FP_WIDTH-1:0] din_a,
    input wire logic [FP_WIDTH-1:0] din_b,
    input wire logic                din_valid,
    input wire logic                acc_restart,
    input wire logic                in_reg_a_ce,
    input wire logic                in_reg_b_ce,
    input wire logic                pipe_ce,
    input wire logic [FP_WIDTH-1:0] dout,
    input wire logic [1:0]          dout_status,
    input wire logic                dout_valid,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready
);
    // One clock, any reset voids a check
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !in_reg_rst_n || !pipe_rst_n);

    // Latency of input stage plus two pipe stages
    a_lat_valid: assert property (
        in_reg_a_ce && in_reg_b_ce ##1 pipe_ce ##1 pipe_ce |=> dout_valid == $past(din_valid, 3))
        else $error("result valid out of step");
    // Restart travels with its pair
    a_restart_zero: assert property (
        din_valid && acc_restart && din_a == '0 && din_b == '0 && in_reg_a_ce && in_reg_b_ce
        ##1 pipe_ce ##1 pipe_ce |=> dout == '0 && dout_status == 2'h1)
        else $error("restarted zero product wrong");
    a_zero_mag: assert property (
        dout_valid && dout_status[0] |-> dout[FP_WIDTH-2:0] == '0)
        else $error("zero status with nonzero value");
    // Frozen pipe must not move the result
    a_stall_hold: assert property (
        !pipe_ce |=> $stable(dout) && $stable(dout_valid))
        else $error("result moved while pipe held");
    a_ar_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_b_drop: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");

    // Main scenarios reached
    c_restart: cover property (din_valid && acc_restart);
    c_stall: cover property (!pipe_ce && dout_valid);
    c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind fpm_top fpm_checker #(.FP_WIDTH(FP_WIDTH)) fpm_checker_inst (.aclk, .aresetn, .in_reg_rst_n,
    .pipe_rst_n, .din_a, .din_b, .din_valid, .acc_restart, .in_reg_a_ce, .in_reg_b_ce, .pipe_ce,
    .dout, .dout_status, .dout_valid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// file: tb/fpm_fabric.sv
// Fabric-side operand source
`timescale 1ns/100ps
module fpm_fabric (
    input wire logic   aclk,
    input wire logic   aresetn,
    input wire logic   slow,
    input wire logic   res_ready,
    output logic [15:0] din_a,
    output logic [15:0] din_b,
    output logic       din_valid,
    output logic       acc_restart,
    output logic       ce
);
    logic [32:0] pend_q[$]; // Pending {a, b, restart}
    logic        gap = 1'h0; // Slow-mode phase
    logic        stall;      // Frozen cycle

    // Restart rides with the first pair of a sum
    task automatic push(input logic [15:0] a, b, input logic r);
        pend_q.push_back({a, b, r});
    endtask

    initial begin
        {din_a, din_b, din_valid, acc_restart, ce} = {34'h0, 1'h1};
    end

    // Slow mode freezes every other cycle; idle cycles show junk
    always @(posedge aclk) begin
        stall = aresetn && slow && !gap;
        gap <= stall;
        ce <= !stall;
        if (!stall && res_ready === 1'h1 && pend_q.size() > 0) begin
            {din_a, din_b, acc_restart} <= pend_q.pop_front();
            din_valid <= 1'h1;
        end else if (!stall) begin
            din_a <= ~din_a;
            din_b <= din_a;
            acc_restart <= ~acc_restart;
            din_valid <= 1'h0;
        end
    end
endmodule

// file: tb/tb_fp_multiply_accumulate.sv
// Self-checking bench for the multiplier block
`timescale 1ns/100ps
`include "fpm_regs.svh"
module tb_fp_multiply_accumulate;
    logic        aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, lrst_n = 1'h1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, dout_status;
    logic [15:0] din_a, din_b, dout;
    logic        din_valid, acc_restart, ce, dout_valid, res_ready;
    logic [17:0] exp_q[$]; // Expected {status, value}
    int          error_cnt = 0, check_count = 0, cycles = 0;

    // Input stage, two pipe stages, accumulation on
    fpm_top #(.ACCUM_EN(1'h1), .IN_REG_EN(1'h1), .PIPE_REGS(2)) fpm_top_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .din_a, .din_b, .din_valid, .acc_restart, .in_reg_a_ce(ce), .in_reg_b_ce(ce),
        .in_reg_rst_n(lrst_n), .pipe_ce(ce), .pipe_rst_n(lrst_n), .dout, .dout_status, .dout_valid,
        .res_ready);
    fpm_fabric fpm_fabric_inst (.aclk, .aresetn, .slow, .res_ready, .din_a, .din_b, .din_valid,
        .acc_restart, .ce);

    always #25 aclk = ~aclk;

    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, want);
        check_count++;
        if (got !== want) begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, want);
        end
    endtask

    // Extra result fails against unknown
    task automatic chk_res(input logic [17:0] got);
        chk_reg({14'h0, got}, exp_q.size() > 0 ? {14'h0, exp_q.pop_front()} : 'x);
    endtask

    // Bus write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk_reg({30'h0, s_axi_bresp}, 32'h0);
    endtask

    // Bus read; ready raised late
    task automatic rd(input logic [3:0] a, input logic [31:0] m, w, input logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
        chk_reg(s_axi_rdata & m, w);
        chk_reg({30'h0, s_axi_rresp}, {30'h0, resp});
    endtask

    task automatic op(input logic [15:0] a, b, input logic r, logic [15:0] v, logic [1:0] s);
        fpm_fabric_inst.push(a, b, r);
        exp_q.push_back({s, v});
    endtask

    task automatic drain();
        while (exp_q.size() > 0) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask

    // Take results on edges that advance the pipe
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (aresetn && dout_valid === 1'h1 && ce === 1'h1) chk_res({dout_status, dout});
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`FPM_OFF_CTRL, 32'hFFFFFFFF, 32'h1, `FPM_RESP_OKAY);
        wr(`FPM_OFF_CONFIG, 32'h0);
        rd(`FPM_OFF_CONFIG, 32'hFFFFFFFF, 32'h00230510, `FPM_RESP_OKAY);
        rd(4'h2, 32'hFFFFFFFF, 32'h0, `FPM_RESP_DECERR);
        wr(`FPM_OFF_CTRL, 32'h0);
        op(16'h3C00, 16'h4000, 1'h1, 16'h4000, 2'h0);
        op(16'h4000, 16'h4200, 1'h0, 16'h4800, 2'h0);
        op(16'h3C00, 16'h3C00, 1'h0, 16'h4880, 2'h0);
        op(16'h3E00, 16'h4000, 1'h1, 16'h4200, 2'h0);
        op(16'h0000, 16'h0000, 1'h1, 16'h0000, 2'h1);
        op(16'h7C00, 16'h4000, 1'h1, 16'h7C00, 2'h2);
        op(16'h0400, 16'h0400, 1'h1, 16'h0000, 2'h3);
        drain();
        {slow, lrst_n} <= 2'h2;
        @(negedge aclk) op(16'h3C00, 16'h4000, 1'h0, 16'h4000, 2'h0);
        @(posedge aclk) lrst_n <= 1'h1;
        op(16'h4000, 16'h4200, 1'h0, 16'h4800, 2'h0);
        drain();
        slow <= 1'h0;
        wr(`FPM_OFF_CTRL, 32'h1);
        op(16'h3C00, 16'h4000, 1'h1, 16'h4000, 2'h0);
        op(16'h0000, 16'h0000, 1'h1, 16'h0000, 2'h1);
        drain();
        rd(`FPM_OFF_STATUS, 32'h300, 32'h300, `FPM_RESP_OKAY);
        chk_reg({31'h0, res_ready}, 32'h0);
        rd(`FPM_OFF_RESULT, 32'hFFFFFFFF, 32'h80004000, `FPM_RESP_OKAY);
        rd(`FPM_OFF_RESULT, 32'hFFFFFFFF, 32'h81000000, `FPM_RESP_OKAY);
        rd(`FPM_OFF_RESULT, 32'hFFFFFFFF, 32'h0, `FPM_RESP_OKAY);
        rd(`FPM_OFF_STATUS, 32'h300, 32'h0, `FPM_RESP_OKAY);
        report_and_stop();
    end
endmodule
